// [core/tfh_core.v]
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`include "tfh_map.vh"
module tfh_core (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         intrq,
  output reg         dmarq,
  input  wire        media_ready,
  input  wire        media_error,
  output reg  [15:0] media_wdata,
  output reg         media_wvalid,
  output reg         media_ecc
);

  // st_rel holds a released queued write until the host sends service
  localparam ST_IDLE = 2'b00;
  localparam ST_REL  = 2'b01;
  localparam ST_XFER = 2'b10;
  localparam ST_ECC  = 2'b11;

  // the kind picks block interrupts and the completion report
  localparam K_QUEUE = 2'b00;
  localparam K_LONG  = 2'b01;
  localparam K_MULT  = 2'b10;

  reg [1:0]  state;
  reg [1:0]  kind;
  reg [7:0]  feature_in;
  reg [7:0]  error_out;
  reg [7:0]  sector_count_tag;
  reg [7:0]  start_sector_low;
  reg [7:0]  cylinder_low_byte;
  reg [7:0]  cylinder_high_byte;
  reg [7:0]  drive_head_select;
  reg        err_flag;
  reg        srv;
  reg [4:0]  tag;
  reg [27:0] lba;
  reg        cfg_ecc52;
  reg [7:0]  cfg_blk;
  reg [31:0] next_rdata;
  reg        next_slverr;

  wire [8:0] sec_cnt;
  wire [8:0] word_cnt;
  wire [8:0] blk_cnt;

  // a transfer completes on the edge where pready is seen high
  wire acc      = psel & penable & pready;
  wire wr       = acc & pwrite;
  wire drq      = (state == ST_XFER) | (state == ST_ECC);
  wire wr_cmd   = wr & (paddr == `TFH_A_CMD);
  wire wr_data  = wr & (paddr == `TFH_A_DATA) & drq;
  wire rd_stat  = acc & ~pwrite & (paddr == `TFH_A_CMD);
  wire idle     = (state == ST_IDLE);
  wire fail     = drq & media_error;
  wire wr_ok    = wr_data & ~media_error;
  wire last_u   = (word_cnt == `TFH_ONE);
  wire last_sec = (sec_cnt == `TFH_ONE);
  wire last_blk = (blk_cnt == `TFH_ONE);
  wire [7:0] blk_size = cfg_blk;

  // commands are decoded from the write data of the command access
  wire is_queue = (pwdata[7:0] == `TFH_CMD_QDMA);
  wire is_long  = (pwdata[7:1] == `TFH_CMD_LONG7);
  wire is_mult  = (pwdata[7:0] == `TFH_CMD_MULT);
  wire start    = wr_cmd & idle & (is_queue | is_long | is_mult);
  wire abort    = wr_cmd & idle & ~(is_queue | is_long | is_mult);
  // reselection only counts once the device has signalled readiness
  wire service  = wr_cmd & (state == ST_REL) & srv &
                  (pwdata[7:0] == `TFH_CMD_SVC);

  // a sector ends on its last data word, except long write goes to ecc
  wire sec_end  = wr_ok & last_u & (state == ST_XFER) & (kind != K_LONG);
  wire long_ecc = wr_ok & last_u & (state == ST_XFER) & (kind == K_LONG);
  wire done_ok  = (wr_ok & last_u & (state == ST_ECC)) | (sec_end & last_sec);
  wire [27:0] start_lba = {drive_head_select[3:0], cylinder_high_byte,
                           cylinder_low_byte, start_sector_low};

  reg       sec_load;
  reg [8:0] sec_val;
  reg       word_load;
  reg [8:0] word_val;
  reg       blk_load;

  always @* begin
    sec_load  = start;
    sec_val   = `TFH_ONE;
    word_load = start | sec_end | long_ecc;
    word_val  = `TFH_SEC_WORDS;
    blk_load  = start | (sec_end & last_blk);
    if (is_queue) begin
      sec_val = (feature_in == 8'h00) ? `TFH_FULL_CNT
                                      : {1'b0, feature_in};
    end else if (is_mult) begin
      sec_val = (sector_count_tag == 8'h00) ? `TFH_FULL_CNT
                : {1'b0, sector_count_tag};
    end
    if (long_ecc) begin
      word_val = cfg_ecc52 ? `TFH_ECC_LONG : `TFH_ECC_SHORT;
    end
  end

  // sectors left in the command, items left in the sector and sectors left in the block
  tfh_cnt #(.W(9)) u_sec (
    .clk      (pclk),
    .rst_n    (presetn),
    .load     (sec_load),
    .load_val (sec_val),
    .dec      (sec_end),
    .count    (sec_cnt)
  );

  tfh_cnt #(.W(9)) u_word (
    .clk      (pclk),
    .rst_n    (presetn),
    .load     (word_load),
    .load_val (word_val),
    .dec      (wr_ok),
    .count    (word_cnt)
  );

  tfh_cnt #(.W(9)) u_blk (
    .clk      (pclk),
    .rst_n    (presetn),
    .load     (blk_load),
    .load_val ({1'b0, blk_size}),
    .dec      (sec_end),
    .count    (blk_cnt)
  );

  // register read mux; rdy and df are fixed, bsy never set here
  always @* begin
    next_rdata  = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr)
      `TFH_A_DATA:  next_rdata = 32'h0000_0000;
      `TFH_A_FEAT:  next_rdata[7:0] = error_out;
      `TFH_A_SCNT:  next_rdata[7:0] = sector_count_tag;
      `TFH_A_SNUM:  next_rdata[7:0] = start_sector_low;
      `TFH_A_CYLL:  next_rdata[7:0] = cylinder_low_byte;
      `TFH_A_CYLH:  next_rdata[7:0] = cylinder_high_byte;
      `TFH_A_DHEAD: next_rdata[7:0] = drive_head_select;
      `TFH_A_CMD: begin
        next_rdata[`TFH_ST_BSY] = 1'b0;
        next_rdata[`TFH_ST_RDY] = 1'b1;
        next_rdata[`TFH_ST_DF]  = 1'b0;
        next_rdata[`TFH_ST_SRV] = srv;
        next_rdata[`TFH_ST_DRQ] = drq;
        next_rdata[`TFH_ST_ERR] = err_flag;
      end
      `TFH_A_CFG: begin
        next_rdata[`TFH_CFG_ECC] = cfg_ecc52;
        next_rdata[`TFH_CFG_BLK_HI:`TFH_CFG_BLK_LO] = cfg_blk;
      end
      default: next_slverr = 1'b1;
    endcase
  end

  // zero wait states: the setup cycle prepares the answer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= next_rdata;
      pslverr <= psel & ~penable & next_slverr;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      media_wvalid <= 1'b0;
      media_wdata  <= 16'h0000;
      media_ecc    <= 1'b0;
    end else begin
      media_wvalid <= wr_ok;
      media_ecc    <= (state == ST_ECC);
      if (wr_ok) begin
        // ecc bytes use only the low lane
        media_wdata <= (state == ST_ECC) ? {8'h00, pwdata[7:0]}
                                         : pwdata[15:0];
      end
    end
  end

  // interrupt: set wins over the clear by a status read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intrq <= 1'b0;
    end else if (abort | done_ok | fail) begin
      intrq <= 1'b1;
    end else if (sec_end & last_blk & (kind == K_MULT)) begin
      intrq <= 1'b1;
    end else if (rd_stat) begin
      intrq <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state              <= ST_IDLE;
      kind               <= K_QUEUE;
      feature_in         <= 8'h00;
      error_out          <= 8'h00;
      sector_count_tag   <= 8'h00;
      start_sector_low   <= 8'h00;
      cylinder_low_byte  <= 8'h00;
      cylinder_high_byte <= 8'h00;
      drive_head_select  <= 8'h00;
      err_flag           <= 1'b0;
      srv                <= 1'b0;
      tag                <= 5'h00;
      lba                <= 28'h000_0000;
      dmarq              <= 1'b0;
      cfg_ecc52          <= 1'b0;
      cfg_blk            <= `TFH_BLK_RST;
    end else begin
      // the task file is frozen while a command owns it
      if (wr & idle) begin
        case (paddr)
          `TFH_A_FEAT:  feature_in         <= pwdata[7:0];
          `TFH_A_SCNT:  sector_count_tag   <= pwdata[7:0];
          `TFH_A_SNUM:  start_sector_low   <= pwdata[7:0];
          `TFH_A_CYLL:  cylinder_low_byte  <= pwdata[7:0];
          `TFH_A_CYLH:  cylinder_high_byte <= pwdata[7:0];
          `TFH_A_DHEAD: drive_head_select  <= pwdata[7:0];
          `TFH_A_CFG: begin
            cfg_ecc52 <= pwdata[`TFH_CFG_ECC];
            // a zero block size would never raise a block interrupt
            if (pwdata[`TFH_CFG_BLK_HI:`TFH_CFG_BLK_LO] != 8'h00) begin
              cfg_blk <= pwdata[`TFH_CFG_BLK_HI:`TFH_CFG_BLK_LO];
            end
          end
          default: ;
        endcase
      end
      if (abort) begin
        error_out <= 8'h00;
        error_out[`TFH_ER_ABT] <= 1'b1;
        err_flag  <= 1'b1;
      end
      if (start) begin
        error_out <= 8'h00;
        err_flag  <= 1'b0;
        lba       <= start_lba;
        tag       <= sector_count_tag[7:3];
        state     <= ST_XFER;
        if (is_queue) begin
          kind <= K_QUEUE;
          if (media_ready) begin
            srv   <= 1'b1;
            dmarq <= 1'b1;
          end else begin
            state <= ST_REL;
            srv   <= 1'b0;
            sector_count_tag <= {sector_count_tag[7:3],
                                 `TFH_SC_REL};
          end
        end else if (is_long) begin
          kind <= K_LONG;
        end else begin
          kind <= K_MULT;
        end
      end
      // srv follows the medium one cycle late; service is refused before it
      if (state == ST_REL) begin
        if (media_ready) begin
          srv <= 1'b1;
        end
        if (service) begin
          state <= ST_XFER;
          dmarq <= 1'b1;
        end
      end
      if (sec_end) begin
        lba <= lba + 28'h000_0001;
      end
      if (long_ecc) begin
        state <= ST_ECC;
      end
      // no release path from here: the data phase runs to its end
      if (done_ok | fail) begin
        state <= ST_IDLE;
        dmarq <= 1'b0;
        srv   <= 1'b0;
        case (kind)
          K_QUEUE: sector_count_tag <= {tag, `TFH_SC_DONE};
          K_LONG:  sector_count_tag <= fail ? 8'h01 : 8'h00;
          // limitation: 256 sectors still owed read back as zero
          default: sector_count_tag <= fail ? sec_cnt[7:0] : 8'h00;
        endcase
      end
      // software finds the failing sector in the task file after an error
      if (fail) begin
        error_out <= 8'h00;
        error_out[`TFH_ER_IDN] <= 1'b1;
        err_flag  <= 1'b1;
        start_sector_low   <= lba[7:0];
        cylinder_low_byte  <= lba[15:8];
        cylinder_high_byte <= lba[23:16];
        drive_head_select  <= {drive_head_select[7:4], lba[27:24]};
      end
    end
  end

endmodule // tfh_core

// [common/tfh_map.vh]
`ifndef TFH_MAP_VH
`define TFH_MAP_VH

// register byte addresses on the apb side
`define TFH_A_DATA     8'h00
`define TFH_A_FEAT     8'h04
`define TFH_A_SCNT     8'h08
`define TFH_A_SNUM     8'h0c
`define TFH_A_CYLL     8'h10
`define TFH_A_CYLH     8'h14
`define TFH_A_DHEAD    8'h18
`define TFH_A_CMD      8'h1c
`define TFH_A_CFG      8'h20

// command codes
`define TFH_CMD_QDMA   8'hcc
`define TFH_CMD_LONG7  7'h19
`define TFH_CMD_MULT   8'hc5
`define TFH_CMD_SVC    8'ha2

// status bit positions
`define TFH_ST_BSY     7
`define TFH_ST_RDY     6
`define TFH_ST_DF      5
`define TFH_ST_SRV     4
`define TFH_ST_DRQ     3
`define TFH_ST_ERR     0

// error bit positions
`define TFH_ER_IDN     4
`define TFH_ER_ABT     2

// sector count low field on release and completion
`define TFH_SC_REL     3'h4
`define TFH_SC_DONE    3'h3

// configuration fields and reset values
`define TFH_CFG_ECC    0
`define TFH_CFG_BLK_HI 15
`define TFH_CFG_BLK_LO 8
`define TFH_BLK_RST    8'h01

// transfer counts
`define TFH_FULL_CNT   9'h100
`define TFH_ONE        9'h001
`define TFH_SEC_WORDS  9'h100
`define TFH_ECC_SHORT  9'h004
`define TFH_ECC_LONG   9'h034

`endif

// [core/tfh_cnt.v]
`timescale 1ns/100ps
// loadable down counter; a load wins over a decrement
module tfh_cnt #(
  parameter W = 9
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         load,
  input  wire [W-1:0] load_val,
  input  wire         dec,
  output reg  [W-1:0] count
);

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {W{1'b0}};
    end else if (load) begin
      count <= load_val;
    end else if (dec) begin
      count <= count - {{(W-1){1'b0}}, 1'b1};
    end
  end

endmodule // tfh_cnt

// [verif/tfh_media_model.sv]
`timescale 1ns/100ps
module tfh_media_model (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        stall,
  input  wire        inject,
  input  wire [15:0] media_wdata,
  input  wire        media_wvalid,
  input  wire        media_ecc,
  output logic       media_ready,
  output logic       media_error
);
  int words;
  int eccs;

  // stall models a slow medium, which makes the queued write release
  assign media_ready = !stall;
  // inject models an unrecoverable fault while data is requested
  assign media_error = inject;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      words <= 0;
      eccs  <= 0;
    end else if (media_wvalid) begin
      if (media_ecc)
        eccs <= eccs + 1;
      else
        words <= words + 1;
    end
  end
endmodule // tfh_media_model

// [verif/tfh_core_monitor.sv]
`timescale 1ns/100ps
module tfh_core_monitor (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [7:0]  paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire        intrq,
  input wire        dmarq,
  input wire        media_ready,
  input wire        media_error,
  input wire [15:0] media_wdata,
  input wire        media_wvalid,
  input wire        media_ecc
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_next: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_slverr_unmapped: assert property (pready && paddr > 8'h20 |-> pslverr)
    else $error("unmapped access not refused");
  a_slverr_mapped: assert property (pready && paddr <= 8'h20
    && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  a_rdata_upper: assert property (pready && !pwrite && paddr != 8'h00
    |-> prdata[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_word_data: assert property (media_wvalid && !media_ecc
    |-> media_wdata == $past(pwdata[15:0]))
    else $error("sector word corrupted");
  a_ecc_byte: assert property (media_wvalid && media_ecc
    |-> media_wdata[7:0] == $past(pwdata[7:0]))
    else $error("ecc byte corrupted");
  a_wvalid_cause: assert property (media_wvalid |-> $past(psel && penable
    && pready && pwrite && paddr == 8'h00))
    else $error("media write without data write");
  a_dmarq_start: assert property ($rose(dmarq) |->
    $past(pwrite && pready && paddr == 8'h1c)
    || $past(pwrite && pready && paddr == 8'h1c, 2))
    else $error("dmarq rose without command");
  a_dmarq_hold: assert property ($fell(dmarq) |-> media_wvalid
    || $past(media_wvalid) || $past(media_error) || $past(media_error, 2))
    else $error("dmarq dropped mid transfer");
endmodule // tfh_core_monitor

bind tfh_core tfh_core_monitor mon_u (
  .pclk         (pclk),
  .presetn      (presetn),
  .psel         (psel),
  .penable      (penable),
  .pwrite       (pwrite),
  .paddr        (paddr),
  .pwdata       (pwdata),
  .prdata       (prdata),
  .pready       (pready),
  .pslverr      (pslverr),
  .intrq        (intrq),
  .dmarq        (dmarq),
  .media_ready  (media_ready),
  .media_error  (media_error),
  .media_wdata  (media_wdata),
  .media_wvalid (media_wvalid),
  .media_ecc    (media_ecc)
);

// [verif/tb_ata_write_command_handler.sv]
`timescale 1ns/100ps
`include "tfh_map.vh"
module tb_ata_write_command_handler;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        stall = 1'b0;
  logic        inject = 1'b0;
  logic        err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic        pready, pslverr, intrq, dmarq, media_ready, media_error;
  logic        media_wvalid, media_ecc;
  logic [15:0] media_wdata;
  int          fails = 0;
  int          samples_checked = 0;
  int          w0, e0;

  always #2.5 pclk = ~pclk;

  tfh_core dut_u (
    .pclk         (pclk),
    .presetn      (presetn),
    .psel         (psel),
    .penable      (penable),
    .pwrite       (pwrite),
    .paddr        (paddr),
    .pwdata       (pwdata),
    .prdata       (prdata),
    .pready       (pready),
    .pslverr      (pslverr),
    .intrq        (intrq),
    .dmarq        (dmarq),
    .media_ready  (media_ready),
    .media_error  (media_error),
    .media_wdata  (media_wdata),
    .media_wvalid (media_wvalid),
    .media_ecc    (media_ecc)
  );
  tfh_media_model m_u (
    .pclk         (pclk),
    .presetn      (presetn),
    .stall        (stall),
    .inject       (inject),
    .media_wdata  (media_wdata),
    .media_wvalid (media_wvalid),
    .media_ecc    (media_ecc),
    .media_ready  (media_ready),
    .media_error  (media_error)
  );

  task wrap_up;
    $display("compared %0d, mismatched %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after a rising edge; one idle edge keeps transfers apart
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fails++;
      wrap_up;
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task put(input int n, input logic ecc);
    for (int k = 0; k < n; k++)
      apb(1'b1, `TFH_A_DATA, ecc ? {24'h0, k[7:0]} : {16'h0, k[15:0]});
    // one more edge lets the media model count the last item
    @(posedge pclk);
  endtask

  task t_regs;
    rdc(`TFH_A_CFG, 32'h100);
    rdc(`TFH_A_CMD, 32'h40);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test regs done");
  endtask

  task t_long;
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, `TFH_A_CFG, {16'h0, `TFH_BLK_RST, 7'h0, i[0]});
      apb(1'b1, `TFH_A_SCNT, 32'h1);
      apb(1'b1, `TFH_A_DHEAD, 32'he0);
      w0 = m_u.words;
      e0 = m_u.eccs;
      apb(1'b1, `TFH_A_CMD, {24'h0, `TFH_CMD_LONG7, i[0]});
      put(256, 1'b0);
      put(i ? 52 : 4, 1'b1);
      chk(m_u.words - w0, 256);
      chk(m_u.eccs - e0, i ? 52 : 4);
      chk({31'h0, intrq}, 32'h1);
      rdc(`TFH_A_SCNT, 32'h0);
      rdc(`TFH_A_CMD, 32'h40);
      chk({31'h0, intrq}, 32'h0);
    end
    $display("test long write done");
  endtask

  // pass 0 is held off by the medium and released, pass 1 starts at once
  task t_queued;
    for (int i = 0; i < 2; i++) begin
      stall <= !i;
      apb(1'b1, `TFH_A_FEAT, i ? 32'h2 : 32'h1);
      apb(1'b1, `TFH_A_SCNT, i ? 32'hf8 : 32'h28);
      w0 = m_u.words;
      apb(1'b1, `TFH_A_CMD, `TFH_CMD_QDMA);
      if (i == 0) begin
        rdc(`TFH_A_SCNT, 32'h2c);
        rdc(`TFH_A_CMD, 32'h40);
        chk({31'h0, dmarq}, 32'h0);
        stall <= 1'b0;
        repeat (2) @(posedge pclk);
        rdc(`TFH_A_CMD, 32'h50);
        apb(1'b1, `TFH_A_CMD, `TFH_CMD_SVC);
      end
      chk({31'h0, dmarq}, 32'h1);
      put(256, 1'b0);
      chk({31'h0, dmarq}, i);
      if (i) put(256, 1'b0);
      chk(m_u.words - w0, 256 * (i + 1));
      rdc(`TFH_A_SCNT, i ? 32'hfb : 32'h2b);
      chk({31'h0, intrq}, 32'h1);
      rdc(`TFH_A_CMD, 32'h40);
    end
    $display("test queued write done");
  endtask

  task t_mult;
    apb(1'b1, `TFH_A_SCNT, 32'h2);
    apb(1'b1, `TFH_A_CMD, `TFH_CMD_MULT);
    put(256, 1'b0);
    chk({31'h0, intrq}, 32'h1);
    apb(1'b0, `TFH_A_CMD, 32'h0);
    chk({31'h0, intrq}, 32'h0);
    put(256, 1'b0);
    chk({31'h0, intrq}, 32'h1);
    rdc(`TFH_A_CMD, 32'h40);
    $display("test multiple write done");
  endtask

  // the second sector fails: the task file must point at it afterwards
  task t_fail;
    apb(1'b1, `TFH_A_SNUM, 32'h10);
    apb(1'b1, `TFH_A_CYLL, 32'h20);
    apb(1'b1, `TFH_A_CYLH, 32'h30);
    apb(1'b1, `TFH_A_DHEAD, 32'he1);
    apb(1'b1, `TFH_A_SCNT, 32'h2);
    apb(1'b1, `TFH_A_CMD, `TFH_CMD_MULT);
    put(256, 1'b0);
    rdc(`TFH_A_CMD, 32'h48);
    inject <= 1'b1;
    @(posedge pclk);
    inject <= 1'b0;
    @(posedge pclk);
    chk({31'h0, intrq}, 32'h1);
    rdc(`TFH_A_SCNT, 32'h1);
    rdc(`TFH_A_SNUM, 32'h11);
    rdc(`TFH_A_CYLL, 32'h20);
    rdc(`TFH_A_CYLH, 32'h30);
    rdc(`TFH_A_DHEAD, 32'he1);
    rdc(`TFH_A_FEAT, 32'h10);
    rdc(`TFH_A_CMD, 32'h41);
    $display("test media error done");
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_long;
    t_queued;
    t_mult;
    t_fail;
    wrap_up;
  end
endmodule // tb_ata_write_command_handler
